// ===== src/prioritized_interrupt_pkg.sv
/*
  Constants, field layout and carrier types of the prioritized interrupt unit.
  Assumes a single system clock shared by the core control unit and the peripherals.
*/
package prioritized_interrupt_pkg;

  // ==========================================================
  // sources: clear-pending index equals the peripheral code
  localparam int NUM_SRC = 6;
  localparam int NUM_PROG = 5;
  localparam logic [2:0] SRC_COMP = 3'h0;
  localparam logic [2:0] SRC_TIMER = 3'h1;
  localparam logic [2:0] SRC_TRIAC_FALL = 3'h2;
  localparam logic [2:0] SRC_TRIAC_RISE = 3'h3;
  localparam logic [2:0] SRC_TRIAC_PULSE = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;

  // ==========================================================
  // configuration register indices
  localparam logic [4:0] CFG_MASK_IDX = 5'h00;
  localparam logic [4:0] CFG_PRIO_LO_IDX = 5'h11;
  localparam logic [4:0] CFG_PRIO_HI_IDX = 5'h12;
  localparam logic [7:0] CFG_MASK_RESET = 8'h00;
  localparam logic [7:0] CFG_PRIO_RESET = 8'h00;

  // ==========================================================
  // interrupt_mask_config fields
  localparam int MASK_EXT_BIT = 0;
  localparam int MASK_FIRST_PROG_BIT = 1;
  localparam int EDGE_SEL_BIT = 6;
  localparam int BOD_EN_BIT = 7;

  // ==========================================================
  // priority levels and slots
  localparam int SLOT_W = 3;
  localparam logic [2:0] LVL_EXT = 3'h0;
  localparam logic [2:0] LVL_FIRST_PROG = 3'h1;
  localparam logic [2:0] LVL_LAST_PROG = 3'h5;
  localparam logic [2:0] LVL_MAIN = 3'h6;
  localparam logic [2:0] LVL_NONE = 3'h7;
  localparam int STACK_DEPTH = 7;

  // ==========================================================
  // vector table: three bytes per source
  localparam logic [4:0] VEC_BASE = 5'h03;
  localparam logic [4:0] VEC_STRIDE = 5'h03;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic load;
    logic [4:0] index;
    logic [7:0] data;
  } cfg_write_t;

  typedef struct packed {
    logic userEnable;
    logic userDisable;
    logic macroEnable;
    logic macroDisable;
    logic clearPending;
    logic [2:0] clearIndex;
    logic returnSvc;
    logic evalPoint;
  } core_instr_t;

endpackage

// ===== src/ext_edge_detect.sv
/*
  Synchroniser and selectable edge detector for the external request pin.
  Assumes the pin is asynchronous to clk; one pulse per selected edge.
*/
`timescale 1ns/10ps
module ext_edge_detect
  import prioritized_interrupt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pin and control
  input wire logic pinAsync,
  input wire logic fallingSel,
  // event
  output logic edgePulse
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // ==========================================================
  // two-stage synchroniser, then history for the edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pinAsync;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // one cycle per edge, rising when select is 0
  assign edgePulse = fallingSel ? (prev_q & ~sync_q) : (sync_q & ~prev_q);

  // ==========================================================
  // checks
  property p_edge_once;
    @(posedge clk) disable iff (!resetn)
      edgePulse |=> !edgePulse;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge pulse lasted two cycles");

  property p_edge_dir;
    @(posedge clk) disable iff (!resetn)
      (edgePulse && !fallingSel) |-> ($past(pinAsync, 2) && !$past(pinAsync, 3));
  endproperty
  a_edge_dir: assert property (p_edge_dir) else $error("rising select fired on wrong edge");

endmodule

// ===== src/prioritized_interrupt_unit.sv
/*
  Prioritized interrupt unit: pending flags, masks, level arbiter, dispatch
  and low-power wake-up. Assumes the core control unit drives instruction
  strobes on clk and performs the flag/PC stacking when dispatch is signalled.
*/
// Function
// - any request raises global pending; unmasked it requests highest-priority routine
// - user and macro global masks each block the global request
// - external pin edge: config bit 6 low rising, high falling
// - writing a priority register itself produces an interrupt request
// - mask bit 1 enables source; 0 keeps request pending, not lost
// - mask config bits: ext, comparator, timer, triac fall/rise/pulse; reset zero
// - mask config bit 7 enables the brown-out detector
// - programmable codes: comparator 0, timer 1, triac fall 2, rise 3, pulse 4
// - seven levels, 0 highest; 6 main program, 0 external
// - levels 5 to 1 serve the source coded in their slot
// - priority registers form one 16-bit word; level n at 3(n-1)
// - dispatch jumps to three-byte vector per source; return resumes
// - any unmasked request ends wait; only external ends halt, masked skips service
// - masked request stays pending until enabled or cleared by instruction
// - clearing own request drops running routine to lowest priority
// - evaluate only at boundaries; higher level preempts lower, context stacked
// - clear indices: comparator 0 through external 5
`timescale 1ns/10ps
module prioritized_interrupt_unit
  import prioritized_interrupt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration load from the core
  input wire cfg_write_t cfgWr,
  output logic [7:0] cfgRdData,
  // instruction strobes from the core
  input wire core_instr_t instr,
  // low-power state of the core
  input wire logic waitMode,
  input wire logic haltMode,
  // event sources
  input wire logic [NUM_PROG-1:0] periphEvent,
  input wire logic externalRequestPin,
  // towards the core
  output logic globalPending,
  output logic globalRequest,
  output logic dispatchValid,
  output logic [4:0] vectorAddr,
  output logic [2:0] serviceLevel,
  output logic wakeFromWait,
  output logic wakeFromHalt,
  output logic haltSkipService,
  // supply supervision
  output logic brownOutEnable
);

  // ==========================================================
  // functions
  function automatic logic [2:0] slotOf(input logic [15:0] word, input logic [2:0] lvl);
    logic [3:0] base;
    base = 4'(SLOT_W * (int'(lvl) - 1));
    slotOf = word[base +: SLOT_W];
  endfunction

  function automatic logic [2:0] levelOf(input logic [15:0] word, input logic [2:0] src);
    logic [2:0] lvl;
    lvl = LVL_NONE;
    if (src == SRC_EXT) begin
      lvl = LVL_EXT;
    end else begin
      // scan low priority first so the highest slot wins on duplicates
      for (int n = int'(LVL_LAST_PROG); n >= int'(LVL_FIRST_PROG); n--) begin
        if (slotOf(word, 3'(n)) == src) begin
          lvl = 3'(n);
        end
      end
    end
    levelOf = lvl;
  endfunction

  function automatic logic maskBit(input logic [7:0] cfg, input logic [2:0] src);
    maskBit = (src == SRC_EXT) ? cfg[MASK_EXT_BIT] : cfg[int'(src) + MASK_FIRST_PROG_BIT];
  endfunction

  // ==========================================================
  // state
  logic [7:0] maskCfg_q;
  logic [7:0] prioLo_q;
  logic [7:0] prioHi_q;
  logic [NUM_SRC-1:0] pend_q;
  logic [NUM_SRC-1:0] pend_d;
  logic userEn_q;
  logic macroEn_q;
  logic prioWrite_q;
  logic [2:0] curLevel_q;
  logic [2:0] curSrc_q;
  logic [2:0] sp_q;
  logic [2:0] stackLevel [STACK_DEPTH];
  logic [2:0] stackSrc [STACK_DEPTH];
  logic dispatch_q;
  logic [4:0] vector_q;
  logic [7:0] rdData_q;

  logic extEdge;
  logic [15:0] prioWord;
  logic [NUM_SRC-1:0] enabledPend;
  logic winValid;
  logic [2:0] winSrc;
  logic [2:0] winLevel;
  logic doDispatch;
  logic doReturn;
  logic [2:0] prioReqSrc;

  assign prioWord = {prioHi_q, prioLo_q};

  // ==========================================================
  // external pin
  ext_edge_detect u_ext_edge (
    .clk(clk),
    .resetn(resetn),
    .pinAsync(externalRequestPin),
    .fallingSel(maskCfg_q[EDGE_SEL_BIT]),
    .edgePulse(extEdge)
  );

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      maskCfg_q <= CFG_MASK_RESET;
      prioLo_q <= CFG_PRIO_RESET;
      prioHi_q <= CFG_PRIO_RESET;
    end else if (cfgWr.load) begin
      if (cfgWr.index == CFG_MASK_IDX) begin
        maskCfg_q <= cfgWr.data;
      end else if (cfgWr.index == CFG_PRIO_LO_IDX) begin
        prioLo_q <= cfgWr.data;
      end else if (cfgWr.index == CFG_PRIO_HI_IDX) begin
        prioHi_q <= cfgWr.data;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= CFG_MASK_RESET;
    end else if (cfgWr.index == CFG_MASK_IDX) begin
      rdData_q <= maskCfg_q;
    end else if (cfgWr.index == CFG_PRIO_LO_IDX) begin
      rdData_q <= prioLo_q;
    end else if (cfgWr.index == CFG_PRIO_HI_IDX) begin
      rdData_q <= prioHi_q;
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign cfgRdData = rdData_q;
  assign brownOutEnable = maskCfg_q[BOD_EN_BIT];

  // a priority write raises the source now coded in the level-one slot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prioWrite_q <= 1'b0;
    end else begin
      prioWrite_q <= cfgWr.load &&
        (cfgWr.index == CFG_PRIO_LO_IDX || cfgWr.index == CFG_PRIO_HI_IDX);
    end
  end

  assign prioReqSrc = slotOf(prioWord, LVL_FIRST_PROG);

  // ==========================================================
  // global masks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      userEn_q <= 1'b1;
    end else if (instr.userDisable) begin
      userEn_q <= 1'b0;
    end else if (instr.userEnable) begin
      userEn_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      macroEn_q <= 1'b1;
    end else if (instr.macroDisable) begin
      macroEn_q <= 1'b0;
    end else if (instr.macroEnable) begin
      macroEn_q <= 1'b1;
    end
  end

  // ==========================================================
  // pending flags: a new event beats a clear in the same cycle
  always_comb begin
    logic setBit;
    logic clrBit;
    setBit = 1'b0;
    clrBit = 1'b0;
    pend_d = pend_q;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i == int'(SRC_EXT)) begin
        setBit = extEdge;
      end else begin
        setBit = periphEvent[i] || (prioWrite_q && prioReqSrc == 3'(i));
      end
      clrBit = (doDispatch && winSrc == 3'(i)) ||
        (instr.clearPending && instr.clearIndex == 3'(i));
      pend_d[i] = setBit || (pend_q[i] && !clrBit);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign globalPending = |pend_q;

  // ==========================================================
  // arbiter
  always_comb begin
    logic [2:0] lvl;
    lvl = LVL_NONE;
    winValid = 1'b0;
    winSrc = SRC_COMP;
    winLevel = LVL_NONE;
    for (int i = 0; i < NUM_SRC; i++) begin
      enabledPend[i] = pend_q[i] && maskBit(maskCfg_q, 3'(i));
      lvl = levelOf(prioWord, 3'(i));
      // unassigned sources carry no level and are never served
      if (enabledPend[i] && lvl != LVL_NONE && lvl < winLevel) begin
        winValid = 1'b1;
        winSrc = 3'(i);
        winLevel = lvl;
      end
    end
  end

  assign globalRequest = winValid && (winLevel < curLevel_q) && userEn_q && macroEn_q;
  assign doReturn = instr.returnSvc && (sp_q != 3'h0);
  // a return takes the cycle; the request is seen again at the next boundary
  assign doDispatch = instr.evalPoint && globalRequest && !doReturn &&
    (int'(sp_q) < STACK_DEPTH);

  // ==========================================================
  // running level and nesting stack
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      curLevel_q <= LVL_MAIN;
      curSrc_q <= SRC_COMP;
      sp_q <= 3'h0;
    end else if (doReturn) begin
      curLevel_q <= stackLevel[sp_q - 3'h1];
      curSrc_q <= stackSrc[sp_q - 3'h1];
      sp_q <= sp_q - 3'h1;
    end else if (doDispatch) begin
      curLevel_q <= winLevel;
      curSrc_q <= winSrc;
      sp_q <= sp_q + 3'h1;
    end else if (instr.clearPending && sp_q != 3'h0 && instr.clearIndex == curSrc_q) begin
      curLevel_q <= LVL_MAIN;
    end
  end

  always_ff @(posedge clk) begin
    if (doDispatch && !doReturn) begin
      stackLevel[sp_q] <= curLevel_q;
      stackSrc[sp_q] <= curSrc_q;
    end
  end

  // ==========================================================
  // dispatch to the core
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dispatch_q <= 1'b0;
      vector_q <= VEC_BASE;
    end else begin
      dispatch_q <= doDispatch;
      if (doDispatch) begin
        vector_q <= VEC_BASE + 5'(VEC_STRIDE * winSrc);
      end
    end
  end

  assign dispatchValid = dispatch_q;
  assign vectorAddr = vector_q;
  assign serviceLevel = curLevel_q;

  // ==========================================================
  // low-power wake-up
  assign wakeFromWait = waitMode && (|enabledPend);
  // halt wakes on the external flag regardless of its mask bit
  assign wakeFromHalt = haltMode && pend_q[SRC_EXT];
  assign haltSkipService = wakeFromHalt && !maskCfg_q[MASK_EXT_BIT];

  // ==========================================================
  // checks
  // disable taken, then the cycle in which the mask is in force
  sequence s_user_off;
    instr.userDisable ##1 1'b1;
  endsequence

  property p_event_pending;
    @(posedge clk) disable iff (!resetn)
      periphEvent[SRC_TIMER] |=> globalPending;
  endproperty
  a_event_pending: assert property (p_event_pending) else $error("event did not raise pending");

  property p_user_mask;
    @(posedge clk) disable iff (!resetn)
      s_user_off |-> !globalRequest;
  endproperty
  a_user_mask: assert property (p_user_mask) else $error("request passed user mask");

  property p_prio_write;
    @(posedge clk) disable iff (!resetn)
      (cfgWr.load && cfgWr.index == CFG_PRIO_LO_IDX && cfgWr.data[2:0] == SRC_TIMER
        && cfgWr.data[5:3] != SRC_TIMER) |=> ##1 pend_q[SRC_TIMER];
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority write raised no request");

  property p_masked_hold;
    @(posedge clk) disable iff (!resetn)
      (pend_q[SRC_TRIAC_FALL] && !maskCfg_q[SRC_TRIAC_FALL + 1] && !instr.clearPending)
        |=> pend_q[SRC_TRIAC_FALL];
  endproperty
  a_masked_hold: assert property (p_masked_hold) else $error("masked request was dropped");

  property p_bod;
    @(posedge clk) disable iff (!resetn)
      (cfgWr.load && cfgWr.index == CFG_MASK_IDX) |=>
        brownOutEnable == $past(cfgWr.data[BOD_EN_BIT]);
  endproperty
  a_bod: assert property (p_bod) else $error("brown-out enable not from bit 7");

  property p_ext_wins;
    @(posedge clk) disable iff (!resetn)
      (globalRequest && enabledPend[SRC_EXT]) |-> (winSrc == SRC_EXT && winLevel == LVL_EXT);
  endproperty
  a_ext_wins: assert property (p_ext_wins) else $error("external did not win level 0");

  property p_vector;
    @(posedge clk) disable iff (!resetn)
      doDispatch |=> dispatchValid && vectorAddr == 5'(3 + 3 * $past(winSrc));
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector on dispatch");

  property p_boundary;
    @(posedge clk) disable iff (!resetn)
      !instr.evalPoint |=> !dispatchValid;
  endproperty
  a_boundary: assert property (p_boundary) else $error("dispatch off a boundary");

  property p_clear;
    @(posedge clk) disable iff (!resetn)
      (instr.clearPending && instr.clearIndex == SRC_TRIAC_FALL
        && !periphEvent[SRC_TRIAC_FALL] && !prioWrite_q) |=> !pend_q[SRC_TRIAC_FALL];
  endproperty
  a_clear: assert property (p_clear) else $error("clear index 2 left pending");

  property p_halt_wake;
    @(posedge clk) disable iff (!resetn)
      (haltMode && extEdge) ##1 haltMode |-> wakeFromHalt;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("external edge did not end halt");

  property p_own_clear;
    @(posedge clk) disable iff (!resetn)
      (instr.clearPending && sp_q != 3'h0 && instr.clearIndex == curSrc_q
        && !doReturn && !doDispatch) |=> serviceLevel == LVL_MAIN;
  endproperty
  a_own_clear: assert property (p_own_clear) else $error("own clear did not drop level");

endmodule

// ===== verification/core_event_model.sv
/*
  Behavioural model of the peripheral event sources and external pin,
  plus a dispatch counter seen from the core side.
  Assumes the bench calls fire and setPin from a process clocked by clk.
*/
`timescale 1ns/10ps
module core_event_model
  import prioritized_interrupt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // event sources
  output logic [NUM_PROG-1:0] periphEvent,
  output logic externalRequestPin,
  // dispatch observation
  input wire logic dispatchValid,
  output logic [7:0] dispatchCount
);
  initial begin
    periphEvent = '0;
    externalRequestPin = 1'b0;
  end

  // ==========================================================
  // stimulus
  // one-cycle event, released at the edge that takes it
  task automatic fire(input int src);
    @(posedge clk);
    periphEvent[src] <= 1'b1;
    @(posedge clk);
    periphEvent <= '0;
    #1;
  endtask

  // pin is asynchronous to clk; moving it on the edge is one legal case
  task automatic setPin(input logic level);
    @(posedge clk);
    externalRequestPin <= level;
  endtask

  // ==========================================================
  // dispatch counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dispatchCount <= 8'h00;
    end else if (dispatchValid) begin
      dispatchCount <= dispatchCount + 8'h01;
    end
  end
endmodule

// ===== verification/prioritized_interrupt_unit_tb.sv
/*
  Self-checking bench of the prioritized interrupt unit.
  Assumes core strobes are driven here and sources by core_event_model.
*/
`timescale 1ns/10ps
module prioritized_interrupt_unit_tb import prioritized_interrupt_pkg::*;;
  localparam logic [9:0] UEN = 10'h200;
  localparam logic [9:0] UDIS = 10'h100;
  localparam logic [9:0] MEN = 10'h080;
  localparam logic [9:0] MDIS = 10'h040;
  localparam logic [9:0] RET = 10'h002;
  localparam logic [9:0] EVAL = 10'h001;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  cfg_write_t cfgWr;
  core_instr_t instr;
  logic waitMode;
  logic haltMode;
  logic [NUM_PROG-1:0] periphEvent;
  logic externalRequestPin;
  logic [7:0] cfgRdData;
  logic globalPending, globalRequest, dispatchValid;
  logic [4:0] vectorAddr;
  logic [2:0] serviceLevel;
  logic wakeFromWait, wakeFromHalt, haltSkipService, brownOutEnable;
  logic [7:0] dispatchCount;
  logic [9:0] gmSeq [4] = '{UDIS, UEN, MDIS, MEN};
  int mismatches = 0;
  int totalChecks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  prioritized_interrupt_unit u_prioritized_interrupt_unit (
    .clk(clk),
    .resetn(resetn),
    .cfgWr(cfgWr),
    .cfgRdData(cfgRdData),
    .instr(instr),
    .waitMode(waitMode),
    .haltMode(haltMode),
    .periphEvent(periphEvent),
    .externalRequestPin(externalRequestPin),
    .globalPending(globalPending),
    .globalRequest(globalRequest),
    .dispatchValid(dispatchValid),
    .vectorAddr(vectorAddr),
    .serviceLevel(serviceLevel),
    .wakeFromWait(wakeFromWait),
    .wakeFromHalt(wakeFromHalt),
    .haltSkipService(haltSkipService),
    .brownOutEnable(brownOutEnable)
  );

  core_event_model u_core_event_model (
    .clk(clk),
    .resetn(resetn),
    .periphEvent(periphEvent),
    .externalRequestPin(externalRequestPin),
    .dispatchValid(dispatchValid),
    .dispatchCount(dispatchCount)
  );

  // ==========================================================
  // compare and report
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // core-side access
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cfgWrite(input logic [4:0] idx, input logic [7:0] data);
    @(posedge clk);
    cfgWr <= {1'h1, idx, data};
    @(posedge clk);
    cfgWr.load <= 1'b0;
    #1;
  endtask

  task automatic cfgRead(input logic [4:0] idx, input logic [7:0] exp);
    @(posedge clk);
    cfgWr.index <= idx;
    tick(1);
    chk8("cfgRdData", exp, cfgRdData);
  endtask

  task automatic strobe(input logic [9:0] v);
    @(posedge clk);
    instr <= core_instr_t'(v);
    @(posedge clk);
    instr <= '0;
    #1;
  endtask

  task automatic clearSrc(input logic [2:0] idx);
    strobe({4'h0, 1'h1, idx, 2'h0});
  endtask

  task automatic expectDispatch(input logic [4:0] vec, input logic [2:0] lvl);
    strobe(EVAL);
    chk1("dispatchValid", 1'b1, dispatchValid);
    chk8("vectorAddr", 8'(vec), 8'(vectorAddr));
    chk8("serviceLevel", 8'(lvl), 8'(serviceLevel));
    tick(1);
    chk1("dispatchValid", 1'b0, dispatchValid);
  endtask

  // ==========================================================
  // hang guard, well above the roughly 150 cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    cfgWr <= '0;
    instr <= '0;
    waitMode <= 1'b0;
    haltMode <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    tick(1);
    cfgRead(5'h00, 8'h00);
    chk8("serviceLevel", 8'h06, 8'(serviceLevel));
    chk8("vectorAddr", 8'h03, 8'(vectorAddr));
    // priorities first, while every source is still masked
    cfgWrite(5'h11, 8'hC1);
    tick(2);
    chk1("globalPending", 1'b1, globalPending);
    cfgWrite(5'h12, 8'hA8);
    cfgRead(5'h11, 8'hC1);
    cfgRead(5'h12, 8'hA8);
    cfgWrite(5'h05, 8'hFF);
    cfgRead(5'h05, 8'h00);
    clearSrc(3'h1);
    chk1("globalPending", 1'b0, globalPending);
    // masked comparator request waits, then wins at level 2
    u_core_event_model.fire(0);
    chk1("globalPending", 1'b1, globalPending);
    chk1("globalRequest", 1'b0, globalRequest);
    cfgWrite(5'h00, 8'h86);
    cfgRead(5'h00, 8'h86);
    chk1("brownOutEnable", 1'b1, brownOutEnable);
    chk1("globalRequest", 1'b1, globalRequest);
    @(posedge clk);
    waitMode <= 1'b1;
    tick(1);
    chk1("wakeFromWait", 1'b1, wakeFromWait);
    @(posedge clk);
    waitMode <= 1'b0;
    expectDispatch(5'h03, 3'h2);
    chk1("globalPending", 1'b0, globalPending);
    // timer at level 1 preempts, gated by both global masks
    u_core_event_model.fire(1);
    for (int i = 0; i < 4; i++) begin
      strobe(gmSeq[i]);
      chk1("globalRequest", i[0], globalRequest);
    end
    expectDispatch(5'h06, 3'h1);
    strobe(RET);
    chk8("serviceLevel", 8'h02, 8'(serviceLevel));
    // lower level waits until the running routine clears its own request
    u_core_event_model.fire(4);
    cfgWrite(5'h00, 8'hA6);
    chk1("globalRequest", 1'b0, globalRequest);
    clearSrc(3'h0);
    tick(1);
    chk8("serviceLevel", 8'h06, 8'(serviceLevel));
    chk1("globalRequest", 1'b1, globalRequest);
    expectDispatch(5'h0F, 3'h4);
    strobe(RET);
    strobe(RET);
    chk8("serviceLevel", 8'h06, 8'(serviceLevel));
    // each programmable clear index, 0 to 4, removes its own source
    cfgWrite(5'h00, 8'h00);
    chk1("brownOutEnable", 1'b0, brownOutEnable);
    for (int i = 0; i < NUM_PROG; i++) begin
      u_core_event_model.fire(i);
      chk1("globalPending", 1'b1, globalPending);
      clearSrc(3'(i));
      chk1("globalPending", 1'b0, globalPending);
    end
    // external pin, both edge selections
    u_core_event_model.setPin(1'b1);
    tick(6);
    chk1("globalPending", 1'b1, globalPending);
    clearSrc(3'h5);
    u_core_event_model.setPin(1'b0);
    tick(6);
    chk1("globalPending", 1'b0, globalPending);
    cfgWrite(5'h00, 8'h40);
    u_core_event_model.setPin(1'b1);
    tick(6);
    chk1("globalPending", 1'b0, globalPending);
    // enter halt first so the falling edge itself ends it
    @(posedge clk);
    haltMode <= 1'b1;
    u_core_event_model.setPin(1'b0);
    tick(6);
    chk1("globalPending", 1'b1, globalPending);
    chk1("wakeFromHalt", 1'b1, wakeFromHalt);
    chk1("haltSkipService", 1'b1, haltSkipService);
    cfgWrite(5'h00, 8'h41);
    chk1("haltSkipService", 1'b0, haltSkipService);
    @(posedge clk);
    haltMode <= 1'b0;
    expectDispatch(5'h12, 3'h0);
    tick(6);
    chk1("globalPending", 1'b0, globalPending);
    strobe(RET);
    // same code in two slots: the higher level is used
    cfgWrite(5'h11, 8'h09);
    tick(2);
    chk1("globalPending", 1'b1, globalPending);
    cfgWrite(5'h00, 8'h04);
    expectDispatch(5'h06, 3'h1);
    strobe(RET);
    chk8("dispatchCount", 8'h05, dispatchCount);
    results();
  end
endmodule
